// [src/cam_config_and_alert_mask.sv]
`default_nettype none
// Function
// - Bit five bypasses core-rail input divider
// - Bit six selects single-channel conversion mode
// - Single-channel mode converts chosen input continuously
// - Channel from 0x55 bits 7:5, reserved codes
// - Shutdown drives all fans to inactive level
// - Shutdown makes duty-cycle reads return zero
// - Write lock makes config two read-only
// - Config and masks reset to zero
// - Mask one bits 1,2 block voltage alerts
// - Mask one bits 4-6 block temperature alerts
// - Mask one bit 7 blocks group two
// - Mask two bit 1 blocks overheat alerts
// - Mask two bits 2-4 block fan faults
// - Bit five blocks fan four or timer
// - Bits 6,7 block diode fault alerts
// - Alert output only when alert pin enabled
module cam_config_and_alert_mask
    import cam_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    input  wire logic       write_lock,
    input  wire logic       alert_pin_enable,
    input  wire logic       polarity_flip,
    input  wire logic       speed_input_four_is_overheat,
    input  wire logic [7:0] chan_select_reg,
    input  wire logic [7:0] duty_current [CAM_NUM_FANS],
    input  wire logic [7:0] status_one,
    input  wire logic [7:0] status_two,
    input  wire logic [3:0] fan_drive_in,
    output logic      [3:0] fan_drive_out,
    output logic            bypass_input_divider,
    output logic            single_channel_mode,
    output logic            round_robin_enable,
    output logic      [2:0] single_channel_mode_channel,
    output logic            single_channel_mode_channel_valid,
    output logic            power_down_bit,
    output logic            alert_n_out,
    output logic            alert_n_oe
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] config_two;
        logic [7:0] alert_mask_one;
        logic [7:0] alert_mask_two;
        logic [7:0] rdata;
        logic       hit;
        logic       alert;
    } cam_state_type;

    cam_state_type st_r;
    cam_state_type st_nxt;

    function automatic logic is_duty_addr(input logic [7:0] a);
        is_duty_addr = (a >= CAM_ADDR_DUTY_CUR1) && (a <= CAM_ADDR_DUTY_CUR3);
    endfunction

    function automatic logic is_reserved_chan(input logic [2:0] c);
        is_reserved_chan = (c == CAM_CH_RSV0) || (c == CAM_CH_RSV3) || (c == CAM_CH_RSV4);
    endfunction

    logic [7:0] m1;
    logic [7:0] m2;
    logic [7:0] pass_one;
    logic [7:0] pass_two;
    logic [2:0] sel;
    logic       wr_cfg_ok;

    assign m1  = st_r.alert_mask_one;
    assign m2  = st_r.alert_mask_two;
    assign sel = chan_select_reg[CAM_CHAN_SEL_LSB +: 3];

    // ----------------------------------------
    // Alert gating
    // ----------------------------------------
    // Status is recorded outside; only the alert path is masked
    always_comb begin
        pass_one = status_one & ~m1;
        pass_one[CAM_BIT_GROUP_TWO_LIMIT] = 1'b0;
        pass_one[3] = status_one[3];
        pass_one[0] = status_one[0];
        // Group mask overrides every per-source bit of the second status byte
        // Fan four bit covers the timer event too when its pin serves as overheat input
        pass_two = m1[CAM_BIT_GROUP_TWO_LIMIT] ? 8'h00 : (status_two & ~m2);
        pass_two[0] = 1'b0;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        wr_cfg_ok = reg_wr && (reg_addr == CAM_ADDR_CONFIG_TWO) && !write_lock;
        if (wr_cfg_ok) begin
            st_nxt.config_two = reg_wdata;
        end
        if (reg_wr && (reg_addr == CAM_ADDR_MASK_ONE)) begin
            st_nxt.alert_mask_one = reg_wdata;
        end
        if (reg_wr && (reg_addr == CAM_ADDR_MASK_TWO)) begin
            st_nxt.alert_mask_two = reg_wdata;
        end
        st_nxt.hit   = 1'b0;
        st_nxt.rdata = st_r.rdata;
        if (reg_rd) begin
            st_nxt.hit = 1'b1;
            unique case (reg_addr)
                CAM_ADDR_CONFIG_TWO: st_nxt.rdata = st_r.config_two;
                CAM_ADDR_MASK_ONE:   st_nxt.rdata = st_r.alert_mask_one;
                CAM_ADDR_MASK_TWO:   st_nxt.rdata = st_r.alert_mask_two;
                default: begin
                    st_nxt.hit   = 1'b0;
                    st_nxt.rdata = 8'h00;
                end
            endcase
            if (is_duty_addr(reg_addr)) begin
                st_nxt.hit   = 1'b1;
                // Shutdown hides the live duty so software sees fans idle
                st_nxt.rdata = st_r.config_two[CAM_BIT_POWER_DOWN] ? CAM_DUTY_OFF
                             : duty_current[2'(reg_addr - CAM_ADDR_DUTY_CUR1)];
            end
        end
        st_nxt.alert = alert_pin_enable && ((|pass_one) || (|pass_two));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r.config_two     <= CAM_RST_CONFIG_TWO;
            st_r.alert_mask_one <= CAM_RST_MASK_ONE;
            st_r.alert_mask_two <= CAM_RST_MASK_TWO;
            st_r.rdata          <= 8'h00;
            st_r.hit            <= 1'b0;
            st_r.alert          <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata            = st_r.rdata;
    assign reg_hit              = st_r.hit;
    assign bypass_input_divider = st_r.config_two[CAM_BIT_BYPASS_DIVIDER];
    assign single_channel_mode  = st_r.config_two[CAM_BIT_SINGLE_CHANNEL];
    assign round_robin_enable   = ~st_r.config_two[CAM_BIT_SINGLE_CHANNEL];
    assign single_channel_mode_channel         = sel;
    assign single_channel_mode_channel_valid   = single_channel_mode && !is_reserved_chan(sel);
    assign power_down_bit       = st_r.config_two[CAM_BIT_POWER_DOWN];

    genvar g;
    generate
        for (g = 0; g < CAM_NUM_FANS; g++) begin : g_fan
            // Inactive level follows polarity so the fan stops either way
            assign fan_drive_out[g] = power_down_bit ? polarity_flip : fan_drive_in[g];
        end
    endgenerate

    // Open-drain, active low: drive low from one clock after an unmasked event is seen until one clock after it clears
    assign alert_n_out = 1'b0;
    assign alert_n_oe  = st_r.alert;

endmodule
`default_nettype wire

// [src/cam_pkg.sv]
`default_nettype none
package cam_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] CAM_ADDR_CONFIG_TWO  = 8'h73;
    localparam logic [7:0] CAM_ADDR_MASK_ONE    = 8'h74;
    localparam logic [7:0] CAM_ADDR_MASK_TWO    = 8'h75;
    localparam logic [7:0] CAM_ADDR_CHAN_SELECT = 8'h55;
    localparam logic [7:0] CAM_ADDR_DUTY_CUR1   = 8'h30;
    localparam logic [7:0] CAM_ADDR_DUTY_CUR3   = 8'h32;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] CAM_RST_CONFIG_TWO = 8'h00;
    localparam logic [7:0] CAM_RST_MASK_ONE   = 8'h00;
    localparam logic [7:0] CAM_RST_MASK_TWO   = 8'h00;
    localparam logic [7:0] CAM_DUTY_OFF       = 8'h00;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CAM_BIT_BYPASS_DIVIDER   = 5;
    localparam int CAM_BIT_SINGLE_CHANNEL   = 6;
    localparam int CAM_BIT_POWER_DOWN       = 7;
    localparam int CAM_BIT_CORE_RAIL        = 1;
    localparam int CAM_BIT_SUPPLY_33        = 2;
    localparam int CAM_BIT_REMOTE_A_TEMP    = 4;
    localparam int CAM_BIT_LOCAL_TEMP       = 5;
    localparam int CAM_BIT_REMOTE_B_TEMP    = 6;
    localparam int CAM_BIT_GROUP_TWO_LIMIT  = 7;
    localparam int CAM_BIT_OVERHEAT_EVENT   = 1;
    localparam int CAM_BIT_FIRST_FAN        = 2;
    localparam int CAM_BIT_FOURTH_FAN_TIMER = 5;
    localparam int CAM_BIT_REMOTE_A_DIODE   = 6;
    localparam int CAM_BIT_REMOTE_B_DIODE   = 7;
    localparam int CAM_CHAN_SEL_LSB         = 5;
    localparam int CAM_NUM_FANS             = 4;

    // ----------------------------------------
    // Channel codes
    // ----------------------------------------
    typedef enum logic [2:0] {
        CAM_CH_RSV0     = 3'h0,
        CAM_CH_CORE     = 3'h1,
        CAM_CH_SUPPLY   = 3'h2,
        CAM_CH_RSV3     = 3'h3,
        CAM_CH_RSV4     = 3'h4,
        CAM_CH_REMOTE_A = 3'h5,
        CAM_CH_LOCAL    = 3'h6,
        CAM_CH_REMOTE_B = 3'h7
    } cam_chan_type;
endpackage
`default_nettype wire

// [bench/cam_properties.sv]
`default_nettype none
module cam_properties
    import cam_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       write_lock,
    input wire logic       alert_pin_enable,
    input wire logic       bypass_input_divider,
    input wire logic       single_channel_mode,
    input wire logic       round_robin_enable,
    input wire logic       power_down_bit,
    input wire logic       alert_n_out,
    input wire logic       alert_n_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence mask_write_then_read;
        reg_wr && reg_addr == CAM_ADDR_MASK_ONE ##1 !reg_wr && !reg_rd
            ##1 reg_rd && !reg_wr && reg_addr == CAM_ADDR_MASK_ONE;
    endsequence
    AST_ROUND_ROBIN: assert property (round_robin_enable == !single_channel_mode)
        else $error("round robin not inverse of single mode");
    AST_CFG_WRITE: assert property (!write_lock && reg_wr && reg_addr == CAM_ADDR_CONFIG_TWO |=>
        {power_down_bit, single_channel_mode, bypass_input_divider} == $past(reg_wdata[7:5]))
        else $error("config bits do not follow write");
    AST_LOCKED: assert property (write_lock && reg_wr && reg_addr == CAM_ADDR_CONFIG_TWO |=>
        $stable({power_down_bit, single_channel_mode, bypass_input_divider})) else $error("locked write took");
    AST_MASK_READBACK: assert property (mask_write_then_read |=> reg_rdata == $past(reg_wdata, 3))
        else $error("mask readback differs");
    AST_DUTY_OFF: assert property (power_down_bit && reg_rd && reg_addr inside {[CAM_ADDR_DUTY_CUR1:
        CAM_ADDR_DUTY_CUR3]} |=> reg_rdata == CAM_DUTY_OFF) else $error("duty nonzero in shutdown");
    AST_ALERT_OFF: assert property (!alert_pin_enable |=> !alert_n_oe)
        else $error("alert driven while pin disabled");
    AST_ALERT_LEVEL: assert property (alert_n_out == 1'b0)
        else $error("alert level not low");
    AST_RESET_CLEAR: assert property ($fell(rst) |-> !power_down_bit && round_robin_enable)
        else $error("config not clear after reset");
endmodule
bind cam_config_and_alert_mask cam_properties u_props (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .write_lock, .alert_pin_enable, .bypass_input_divider, .single_channel_mode,
    .round_robin_enable, .power_down_bit, .alert_n_out, .alert_n_oe);
`default_nettype wire

// [bench/cam_host.sv]
`default_nettype none
module cam_host (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Register host, strobes one cycle wide
    // ----------------------------------------
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clk);
        #1 reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// [bench/cam_config_and_alert_mask_bench.sv]
`default_nettype none
module cam_config_and_alert_mask_bench;
    import cam_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, write_lock = 1'b0, alert_pin_enable = 1'b1, polarity_flip = 1'b0;
    logic [7:0] chan_select_reg = 8'h00, status_one = 8'h00, status_two = 8'h00, reg_rdata;
    logic [7:0] duty_current [CAM_NUM_FANS] = '{8'h5a, 8'h6b, 8'h7c, 8'h8d};
    logic [3:0] fan_drive_in = 4'h5, fan_drive_out;
    logic reg_hit, bypass_input_divider, single_channel_mode, round_robin_enable, single_channel_mode_channel_valid;
    logic power_down_bit, alert_n_out, alert_n_oe;
    logic [2:0] single_channel_mode_channel;
    logic speed_input_four_is_overheat = 1'b0, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata;
    int failures = 0, checks_done = 0, cyc = 0;
    cam_host host (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    cam_config_and_alert_mask dut (.clk, .rst, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .write_lock,
        .alert_pin_enable, .polarity_flip, .speed_input_four_is_overheat, .chan_select_reg, .duty_current,
        .status_one, .status_two, .fan_drive_in, .fan_drive_out, .bypass_input_divider, .single_channel_mode,
        .round_robin_enable, .single_channel_mode_channel, .single_channel_mode_channel_valid, .power_down_bit, .alert_n_out, .alert_n_oe);
    // ----------------------------------------
    // Checks and closing
    // ----------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task t_reset;
        logic [7:0] v;
        for (int a = 8'h73; a <= 8'h75; a++) begin
            host.rd(a[7:0], v);
            chk(v, 8'h00);
            chk(reg_hit, 1'b1);
        end
    endtask
    task t_cfg;
        logic [7:0] v;
        host.wr(CAM_ADDR_CONFIG_TWO, 8'he0);
        chk({power_down_bit, single_channel_mode, bypass_input_divider, round_robin_enable}, 8'h0e);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            #1 polarity_flip = p[0];
            #1 chk(fan_drive_out, {4{p[0]}});
        end
        host.rd(CAM_ADDR_DUTY_CUR1, v);
        chk(v, CAM_DUTY_OFF);
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            #1 chan_select_reg = {c[2:0], 5'h1f};
            #1 chk(single_channel_mode_channel, c[2:0]);
            chk(single_channel_mode_channel_valid, c inside {1, 2, 5, 6, 7});
        end
        @(posedge clk);
        #1 write_lock = 1'b1;
        host.wr(CAM_ADDR_CONFIG_TWO, 8'h00);
        host.rd(CAM_ADDR_CONFIG_TWO, v);
        chk(v, 8'he0);
        write_lock = 1'b0;
        host.wr(CAM_ADDR_CONFIG_TWO, 8'h00);
        host.rd(CAM_ADDR_DUTY_CUR3, v);
        chk(v, 8'h7c);
        chk(reg_hit, 1'b1);
        chk(fan_drive_out, fan_drive_in);
        chk(single_channel_mode_channel_valid, 1'b0);
    endtask
    // Status moves only after the masks land, so one stale cycle is tolerated
    task alert(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m1, input logic [7:0] m2, input logic e);
        host.wr(CAM_ADDR_MASK_ONE, m1);
        host.wr(CAM_ADDR_MASK_TWO, m2);
        {status_one, status_two} = {a, b};
        repeat (2) @(posedge clk);
        #1 chk(alert_n_oe, e);
    endtask
    task t_masks;
        logic [7:0] b, v;
        for (int i = 1; i < 8; i++) begin
            b = 8'h01 << i;
            if (i != 3 && i != 7) begin
                alert(b, 8'h00, 8'h00, 8'h00, 1'b1);
                alert(b, 8'h00, b, 8'h00, 1'b0);
            end
            alert(8'h00, b, 8'h00, 8'h00, 1'b1);
            alert(8'h00, b, 8'h00, b, 1'b0);
            alert(8'h00, b, 8'h80, 8'h00, 1'b0);
        end
        speed_input_four_is_overheat = 1'b1;
        alert(8'h00, 8'h20, 8'h00, 8'h20, 1'b0);
        alert(8'h00, 8'h20, 8'h00, 8'h00, 1'b1);
        alert_pin_enable = 1'b0;
        alert(8'h76, 8'hfe, 8'h00, 8'h00, 1'b0);
        host.wr(CAM_ADDR_MASK_ONE, 8'h76);
        host.rd(CAM_ADDR_MASK_ONE, v);
        chk(v, 8'h76);
        host.wr(CAM_ADDR_MASK_TWO, 8'hfe);
        host.rd(CAM_ADDR_MASK_TWO, v);
        chk(v, 8'hfe);
    endtask
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        t_reset();
        t_cfg();
        t_masks();
        test_done();
    end
endmodule
`default_nettype wire
